// ---- common/sls_pkg.sv ----
package sls_pkg;

  localparam int TIMER_W = 32;
  localparam int ERR_N   = 5;

  // Clock period and the documented or chosen times in their own units.
  localparam longint CLK_PERIOD_NS = 64'd10;
  localparam longint TRIG_IDLE_S   = 64'd5;
  localparam longint PULSE_MS      = 64'd250;
  localparam longint GAP_MS        = 64'd250;
  localparam longint SEP_MS        = 64'd1500;

  // Least times, rounded up to whole cycles.
  localparam longint TRIG_IDLE_CYC =
    (TRIG_IDLE_S * 64'd1000000000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
  localparam longint PULSE_CYC = (PULSE_MS * 64'd1000000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
  localparam longint GAP_CYC   = (GAP_MS * 64'd1000000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
  localparam longint SEP_CYC   = (SEP_MS * 64'd1000000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;

  // Error slots, scanned in this order when several are active.
  localparam logic [2:0] ERR_TRIG  = 3'h0;
  localparam logic [2:0] ERR_STORE = 3'h1;
  localparam logic [2:0] ERR_LOAD  = 3'h2;
  localparam logic [2:0] ERR_CMDS  = 3'h3;
  localparam logic [2:0] ERR_CFG   = 3'h4;

  localparam logic [3:0] FLASH_TRIG  = 4'h3;
  localparam logic [3:0] FLASH_STORE = 4'h5;
  localparam logic [3:0] FLASH_LOAD  = 4'h6;
  localparam logic [3:0] FLASH_CMDS  = 4'h7;
  localparam logic [3:0] FLASH_CFG   = 4'h8;

  localparam logic [3:0] PULSE_CNT_RST = 4'h0;
  localparam logic [2:0] ERR_IDX_RST   = 3'h0;

  typedef enum logic [2:0] {
    SLS_BOOT  = 3'b000,
    SLS_OK    = 3'b001,
    SLS_PULSE = 3'b010,
    SLS_GAP   = 3'b011,
    SLS_SEP   = 3'b100
  } sls_state_e;

  function automatic logic [3:0] sls_flash_len(input logic [2:0] idx);
    logic [3:0] len;
    len = FLASH_CFG;
    unique case (idx)
      ERR_TRIG:  len = FLASH_TRIG;
      ERR_STORE: len = FLASH_STORE;
      ERR_LOAD:  len = FLASH_LOAD;
      ERR_CMDS:  len = FLASH_CMDS;
      default:   len = FLASH_CFG;
    endcase
    return len;
  endfunction

endpackage

// ---- logic/sls_dur_timer.sv ----
`timescale 1ns/1ps
module sls_dur_timer
  import sls_pkg::*;
#(
  parameter int W = sls_pkg::TIMER_W
) (
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] len_i,
  output logic              done_o
);
  import sls_pkg::*;

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // A load of len_i gives a done pulse len_i cycles later.
  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = len_i;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // The done flag depends on the count alone, so a load made on done forms no loop.
  assign done_o = (count == W'(1));

  chk_tmr_reload: assert property (@(posedge core_clk_i) disable iff (srst_i)
    load_i |=> count == $past(len_i))
    else $error("Timer did not take the loaded duration.");

  chk_tmr_done_once: assert property (@(posedge core_clk_i) disable iff (srst_i)
    done_o |=> !done_o)
    else $error("Timer done lasted more than one cycle.");

endmodule

// ---- logic/sls_trig_watch.sv ----
`timescale 1ns/1ps
module sls_trig_watch
  import sls_pkg::*;
#(
  parameter longint IDLE_CYC = sls_pkg::TRIG_IDLE_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic enable_i,
  input  wire logic line_trigger_input_i,
  output logic      timeout_o
);
  import sls_pkg::*;

  localparam logic [TIMER_W-1:0] LAST = TIMER_W'(IDLE_CYC - 64'd1);

  logic               sync_a;
  logic               sync_b;
  logic               sync_c;
  logic [TIMER_W-1:0] idle_cnt;
  logic [TIMER_W-1:0] next_idle_cnt;
  logic               next_timeout;
  logic               edge_seen;

  assign edge_seen = sync_b ^ sync_c;

  // Any transition restarts the idle count; the flag holds until one comes or enable_i drops.
  always_comb begin
    next_idle_cnt = idle_cnt;
    next_timeout  = timeout_o;
    if (!enable_i || edge_seen) begin
      next_idle_cnt = '0;
      next_timeout  = 1'b0;
    end else if (idle_cnt == LAST) begin
      next_timeout = 1'b1;
    end else begin
      next_idle_cnt = idle_cnt + TIMER_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      sync_c    <= 1'b0;
      idle_cnt  <= '0;
      timeout_o <= 1'b0;
    end else begin
      sync_a    <= line_trigger_input_i;
      sync_b    <= sync_a;
      sync_c    <= sync_b;
      idle_cnt  <= next_idle_cnt;
      timeout_o <= next_timeout;
    end
  end

  chk_trig_edge_clears: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (enable_i && edge_seen) |=> !timeout_o)
    else $error("Trigger transition did not clear the idle flag.");

  chk_trig_idle_time: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(timeout_o) |-> $past(idle_cnt) == LAST && $past(enable_i))
    else $error("Idle flag raised before the full idle time.");

endmodule

// ---- logic/sls_led_signaler.sv ----
`timescale 1ns/1ps
module sls_led_signaler
  import sls_pkg::*;
#(
  parameter longint TRIG_IDLE_CYC = sls_pkg::TRIG_IDLE_CYC,
  parameter longint PULSE_CYC     = sls_pkg::PULSE_CYC,
  parameter longint GAP_CYC       = sls_pkg::GAP_CYC,
  parameter longint SEP_CYC       = sls_pkg::SEP_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic boot_done_i,
  input  wire logic line_trigger_input_i,
  input  wire logic store_fail_i,
  input  wire logic load_fail_i,
  input  wire logic cmd_list_invalid_i,
  input  wire logic logic_cfg_fail_i,
  output logic      led_orange_o,
  output logic      led_green_o
);
  import sls_pkg::*;

  localparam logic [TIMER_W-1:0] PULSE_LEN = TIMER_W'(PULSE_CYC);
  localparam logic [TIMER_W-1:0] GAP_LEN   = TIMER_W'(GAP_CYC);
  localparam logic [TIMER_W-1:0] SEP_LEN   = TIMER_W'(SEP_CYC);

  sls_state_e         state;
  sls_state_e         next_state;
  logic [2:0]         err_idx;
  logic [2:0]         next_err_idx;
  logic [3:0]         pulse_cnt;
  logic [3:0]         next_pulse_cnt;
  logic               next_orange;
  logic               next_green;
  logic               booted;
  logic               trig_timeout;
  logic [ERR_N-1:0]   err_vec;
  logic               any_err;
  logic [2:0]         scan_idx;
  logic [3:0]         code_len;
  logic               tmr_load;
  logic [TIMER_W-1:0] tmr_len;
  logic               tmr_done;

  // Self checks only run once the processor has finished booting.
  assign booted = (state != SLS_BOOT);

  sls_trig_watch #(
    .IDLE_CYC (TRIG_IDLE_CYC)
  ) u_trig_watch (
    .core_clk_i           (core_clk_i),
    .srst_i               (srst_i),
    .enable_i             (booted),
    .line_trigger_input_i (line_trigger_input_i),
    .timeout_o            (trig_timeout)
  );

  sls_dur_timer #(
    .W (TIMER_W)
  ) u_dur_timer (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .load_i     (tmr_load),
    .len_i      (tmr_len),
    .done_o     (tmr_done)
  );

  always_comb begin
    err_vec            = '0;
    err_vec[ERR_TRIG]  = trig_timeout;
    err_vec[ERR_STORE] = store_fail_i;
    err_vec[ERR_LOAD]  = load_fail_i;
    err_vec[ERR_CMDS]  = cmd_list_invalid_i;
    err_vec[ERR_CFG]   = logic_cfg_fail_i;
  end

  assign any_err  = |err_vec;
  assign code_len = sls_flash_len(err_idx);

  // Next active error after the one just shown, wrapping round the slots.
  // The sum is four bits wide because a three-bit sum would wrap at eight.
  always_comb begin
    logic [3:0] sum;
    logic [2:0] cand;
    logic       found;
    sum      = 4'h0;
    cand     = err_idx;
    found    = 1'b0;
    scan_idx = err_idx;
    for (int i = 1; i <= ERR_N; i++) begin
      sum = {1'b0, err_idx} + 4'(i);
      if (sum >= 4'(ERR_N)) begin
        cand = 3'(sum - 4'(ERR_N));
      end else begin
        cand = sum[2:0];
      end
      if (!found && err_vec[cand]) begin
        scan_idx = cand;
        found    = 1'b1;
      end
    end
  end

  always_comb begin
    next_state     = state;
    next_err_idx   = err_idx;
    next_pulse_cnt = pulse_cnt;
    tmr_load       = 1'b0;
    tmr_len        = PULSE_LEN;
    unique case (state)
      SLS_BOOT: begin
        if (boot_done_i) begin
          next_state = SLS_OK;
        end
      end
      SLS_OK: begin
        if (any_err) begin
          next_state     = SLS_PULSE;
          next_err_idx   = scan_idx;
          next_pulse_cnt = PULSE_CNT_RST;
          tmr_load       = 1'b1;
          tmr_len        = PULSE_LEN;
        end
      end
      SLS_PULSE: begin
        if (tmr_done) begin
          next_pulse_cnt = pulse_cnt + 4'h1;
          tmr_load       = 1'b1;
          if (pulse_cnt + 4'h1 == code_len) begin
            next_state = SLS_SEP;
            tmr_len    = SEP_LEN;
          end else begin
            next_state = SLS_GAP;
            tmr_len    = GAP_LEN;
          end
        end
      end
      SLS_GAP: begin
        if (tmr_done) begin
          next_state = SLS_PULSE;
          tmr_load   = 1'b1;
          tmr_len    = PULSE_LEN;
        end
      end
      SLS_SEP: begin
        if (tmr_done) begin
          if (any_err) begin
            next_state     = SLS_PULSE;
            next_err_idx   = scan_idx;
            next_pulse_cnt = PULSE_CNT_RST;
            tmr_load       = 1'b1;
            tmr_len        = PULSE_LEN;
          end else begin
            next_state = SLS_OK;
          end
        end
      end
      default: begin
        next_state = SLS_BOOT;
      end
    endcase
  end

  // Orange during boot, health and pulses; green in gaps and separations.
  always_comb begin
    next_orange = 1'b0;
    next_green  = 1'b0;
    unique case (next_state)
      SLS_BOOT:  next_orange = 1'b1;
      SLS_OK:    next_orange = 1'b1;
      SLS_PULSE: next_orange = 1'b1;
      SLS_GAP:   next_green  = 1'b1;
      SLS_SEP:   next_green  = 1'b1;
      default:   next_orange = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state        <= SLS_BOOT;
      err_idx      <= ERR_IDX_RST;
      pulse_cnt    <= PULSE_CNT_RST;
      led_orange_o <= 1'b1;
      led_green_o  <= 1'b0;
    end else begin
      state        <= next_state;
      err_idx      <= next_err_idx;
      pulse_cnt    <= next_pulse_cnt;
      led_orange_o <= next_orange;
      led_green_o  <= next_green;
    end
  end

  chk_boot_orange: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state == SLS_BOOT && !boot_done_i) |=> led_orange_o && !led_green_o && state == SLS_BOOT)
    else $error("Indicator not orange while booting.");

  chk_ok_steady: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state == SLS_OK && !any_err) [*2] |-> led_orange_o && !led_green_o)
    else $error("Healthy indicator was not steady orange.");

  chk_err_starts: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state == SLS_OK && any_err) |=> state == SLS_PULSE
      && ($past(err_vec) & (ERR_N'(1) << err_idx)) != '0)
    else $error("Active error did not start a flash sequence.");

  chk_gap_green: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state == SLS_GAP) |-> led_green_o && !led_orange_o)
    else $error("Gap between pulses not shown green.");

  chk_pulse_count: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(state == SLS_SEP) |-> pulse_cnt == code_len)
    else $error("Code ended with the wrong pulse count.");

  chk_next_code: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state == SLS_SEP && tmr_done && $countones(err_vec) > 1) |=> err_idx != $past(err_idx))
    else $error("Second active error was not shown next.");

  chk_trig_three: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ($rose(state == SLS_SEP) && err_idx == ERR_TRIG) |-> pulse_cnt == 4'h3)
    else $error("Trigger idle code is not three flashes.");

  chk_store_five: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ($rose(state == SLS_SEP) && err_idx == ERR_STORE) |-> pulse_cnt == 4'h5)
    else $error("Store failure code is not five flashes.");

  chk_load_six: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ($rose(state == SLS_SEP) && err_idx == ERR_LOAD) |-> pulse_cnt == 4'h6)
    else $error("Load failure code is not six flashes.");

  chk_cmds_seven: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ($rose(state == SLS_SEP) && err_idx == ERR_CMDS) |-> pulse_cnt == 4'h7)
    else $error("Command list code is not seven flashes.");

  chk_cfg_eight: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ($rose(state == SLS_SEP) && err_idx == ERR_CFG) |-> pulse_cnt == 4'h8)
    else $error("Configuration failure code is not eight flashes.");

  chk_sep_length: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (next_state == SLS_SEP && state != SLS_SEP) |-> tmr_load && tmr_len == SEP_LEN)
    else $error("Separation did not load its own duration.");

  cov_boot_ok: cover property (@(posedge core_clk_i) disable iff (srst_i)
    state == SLS_BOOT ##1 state == SLS_OK);

  cov_one_code: cover property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(state == SLS_SEP) ##1 state == SLS_SEP);

  cov_two_codes: cover property (@(posedge core_clk_i) disable iff (srst_i)
    state == SLS_SEP && tmr_done && $countones(err_vec) > 1);

  cov_recover: cover property (@(posedge core_clk_i) disable iff (srst_i)
    state == SLS_SEP ##1 state == SLS_OK);

endmodule

// ---- tb/sls_led_observer.sv ----
`timescale 1ns/1ps
module sls_led_observer #(
  parameter int GAP_LIM = 6
) (
  input  wire logic  core_clk_i,
  input  wire logic  led_orange_i,
  input  wire logic  led_green_i,
  output logic [3:0] code_o,
  output logic       code_stb_o,
  output logic       both_on_o
);
  logic [3:0] pulses      = 4'h0;
  logic [7:0] green_run   = 8'h00;
  logic       prev_orange = 1'b0;

  initial begin
    code_o     = 4'h0;
    code_stb_o = 1'b0;
    both_on_o  = 1'b0;
  end

  // The person reading the lamp counts orange pulses and takes a long green
  // stretch as the end of one code; a short green is only a gap.
  always @(posedge core_clk_i) begin
    code_stb_o  <= 1'b0;
    both_on_o   <= both_on_o | (led_orange_i & led_green_i);
    prev_orange <= led_orange_i;
    if (led_green_i) begin
      green_run <= green_run + 8'h01;
    end else begin
      green_run <= 8'h00;
    end
    if (prev_orange && led_green_i) begin
      pulses <= pulses + 4'h1;
    end
    if (green_run == 8'(GAP_LIM) && pulses != 4'h0) begin
      code_o     <= pulses;
      code_stb_o <= 1'b1;
      pulses     <= 4'h0;
    end
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import sls_pkg::*;
  localparam longint IDLE = 200;
  localparam longint PUL  = 4;
  localparam longint GAP  = 3;
  localparam longint SEP  = 10;

  logic       core_clk   = 1'b0;
  logic       srst       = 1'b1;
  logic       boot_done  = 1'b0;
  logic       line_trig  = 1'b0;
  logic       trig_run   = 1'b0;
  logic       trig_kick  = 1'b0;
  logic [3:0] errs       = 4'h0;
  logic       led_orange;
  logic       led_green;
  logic [3:0] code;
  logic       code_stb;
  logic       both_on;
  int         cyc         = 0;
  int         num_errors  = 0;
  int         comparisons = 0;

  sls_led_signaler #(.TRIG_IDLE_CYC(IDLE), .PULSE_CYC(PUL), .GAP_CYC(GAP), .SEP_CYC(SEP)) uut (
    .core_clk_i          (core_clk),
    .srst_i              (srst),
    .boot_done_i         (boot_done),
    .line_trigger_input_i(line_trig),
    .store_fail_i        (errs[0]),
    .load_fail_i         (errs[1]),
    .cmd_list_invalid_i  (errs[2]),
    .logic_cfg_fail_i    (errs[3]),
    .led_orange_o        (led_orange),
    .led_green_o         (led_green)
  );

  sls_led_observer #(.GAP_LIM(int'(GAP) + 3)) observer (
    .core_clk_i  (core_clk),
    .led_orange_i(led_orange),
    .led_green_i (led_green),
    .code_o      (code),
    .code_stb_o  (code_stb),
    .both_on_o   (both_on)
  );

  always #5 core_clk = ~core_clk;

  // The outside trigger source toggles every 20 cycles while it runs.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (trig_kick || (trig_run && (cyc % 20) == 0)) begin
      line_trig <= ~line_trig;
    end
  end

  task automatic check_code(input logic [3:0] got, input logic [3:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %0d want %0d", $time, what, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic steady(input int n, output logic ok);
    ok = 1'b1;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (led_orange !== 1'b1 || led_green !== 1'b0) ok = 1'b0;
    end
  endtask

  task automatic get_code(output logic [3:0] c);
    c = 4'hf;
    for (int i = 0; i < 600; i++) begin
      @(posedge core_clk);
      #1;
      if (code_stb === 1'b1) begin
        c = code;
        break;
      end
    end
  endtask

  task automatic set_errs(input logic [3:0] m);
    @(posedge core_clk);
    errs <= m;
  endtask

  task automatic t_boot;
    logic ok;
    set_errs(4'b0001);
    steady(250, ok);
    check_flag(ok, 1'b1, "orange held in boot");
    set_errs(4'b0000);
    @(posedge core_clk);
    boot_done <= 1'b1;
    trig_run  <= 1'b1;
    steady(100, ok);
    check_flag(ok, 1'b1, "steady orange when healthy");
    $display("test boot done");
  endtask

  task automatic t_single(input logic [3:0] m, input logic [3:0] exp);
    logic [3:0] c;
    logic       ok;
    set_errs(m);
    get_code(c);
    check_code(c, exp, "single code");
    set_errs(4'b0000);
    repeat (8) @(posedge core_clk);
    steady(30, ok);
    check_flag(ok, 1'b1, "back to steady orange");
    $display("test single code %0d done", exp);
  endtask

  task automatic t_trig;
    logic [3:0] c;
    logic       ok;
    int         n;
    @(posedge core_clk);
    trig_run <= 1'b0;
    n = 0;
    while (led_green !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check_flag(n >= IDLE - 22 && n <= IDLE + PUL + 12, 1'b1, "idle delay");
    @(posedge core_clk);
    trig_kick <= 1'b1;
    trig_run  <= 1'b1;
    @(posedge core_clk);
    trig_kick <= 1'b0;
    get_code(c);
    check_code(c, 4'h3, "idle code");
    repeat (10) @(posedge core_clk);
    steady(30, ok);
    check_flag(ok, 1'b1, "steady after trigger resumes");
    $display("test trigger idle done");
  endtask

  task automatic t_multi;
    logic [3:0] c1;
    logic [3:0] c2;
    logic [3:0] c3;
    set_errs(4'b1001);
    get_code(c1);
    get_code(c2);
    set_errs(4'b0100);
    check_flag((c1 === 4'h5 && c2 === 4'h8) || (c1 === 4'h8 && c2 === 4'h5), 1'b1,
               "codes in succession");
    get_code(c3);
    check_code(c3, 4'h7, "next slot after wrap");
    set_errs(4'b0000);
    repeat (40) @(posedge core_clk);
    $display("test two errors done");
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    t_boot;
    t_single(4'b0001, 4'h5);
    t_single(4'b0010, 4'h6);
    t_single(4'b0100, 4'h7);
    t_single(4'b1000, 4'h8);
    t_trig;
    t_multi;
    check_flag(both_on, 1'b0, "both colours lit");
    summarize;
  end

  // The tests need fewer than two thousand cycles; this leaves ample margin.
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize;
  end
endmodule
